/* File: src/gpp_pkg.sv */
// Purpose: constants and carriers for the two-port general I/O block
// Assumes: 8-bit registers on a plain strobe port, one 50 MHz clock
// Notes:   register indices are local choices; no offsets are printed
package gpp_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [2:0] GPP_A_F_DATA  = 3'h0;
	localparam logic [2:0] GPP_A_F_DIR   = 3'h1;
	localparam logic [2:0] GPP_A_G_DATA  = 3'h2;
	localparam logic [2:0] GPP_A_G_DIR   = 3'h3;
	localparam logic [2:0] GPP_A_G_PULL  = 3'h4;
	localparam logic [2:0] GPP_A_STBY    = 3'h5;

	// ****************************************
	// field layout and resets
	// ****************************************
	localparam logic [7:0] GPP_F_MASK    = 8'h07;
	localparam logic [7:0] GPP_G_MASK    = 8'h06;
	localparam logic [7:0] GPP_DIR_RST   = 8'h00;
	localparam logic [7:0] GPP_DATA_RST  = 8'h00;
	localparam logic [7:0] GPP_PULL_RST  = 8'h00;
	localparam logic [7:0] GPP_ZERO8     = 8'h00;
	localparam int         GPP_SPL_BIT   = 0;
	localparam logic [2:0] GPP_F_OD      = 3'h4;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
		logic       rmw;
	} gpp_bus_t;

	typedef struct packed {
		logic [2:0] f_in;
		logic [7:0] g_in;
	} gpp_pins_t;

	typedef struct packed {
		logic [2:0] f_en;
		logic [2:0] f_val;
		logic [7:0] g_en;
		logic [7:0] g_val;
	} gpp_periph_t;

endpackage

/* File: src/gpp_port.sv */
// Purpose: two general I/O ports with direction, latch, standby; pull-up on the second port only
// Assumes: one clock; pin inputs are asynchronous to it
// Notes:   pin pads are split into in, out and active-low output enable
//
// Operation
// - direction bit one makes pin output
// - direction bit zero makes pin input
// - output pin drives latch, writes appear directly
// - input pin write updates latch only
// - output pin read returns latch
// - input read gives pin; modify-write gives latch
// - peripheral enable overrides latch onto pin
// - peripheral-driven read gives pin level
// - reset clears all direction bits
// - standby with bit set: hi-z, inputs clamped low
// - standby with bit clear: pins unchanged
// - pull-up bit one connects pull-up
// - pull-up off while driving low
// - open-drain pin releases on latch one
// - second port uses bits one and two
// - first port uses bits zero to two
// - first port has no pull-up register
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps

module gpp_port
	import gpp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire gpp_bus_t    bus,
	output logic [7:0]       rdata,
	input  wire gpp_pins_t   pin_in,
	output logic [2:0]       f_out,
	output logic [2:0]       f_oe_n,
	output logic [7:0]       g_out,
	output logic [7:0]       g_oe_n,
	output logic [7:0]       g_pullup,
	input  wire gpp_periph_t periph,
	input  wire logic        standby_req,
	output logic [7:0]       pin_level
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [7:0] f_data;
		logic [7:0] f_dir;
		logic [7:0] g_data;
		logic [7:0] g_dir;
		logic [7:0] g_pull;
		logic [7:0] stby;
		logic [10:0] s1;
		logic [10:0] s2;
		logic [10:0] s3;
		logic [10:0] pin;
		logic [7:0] rdata;
		logic [2:0] f_out;
		logic [2:0] f_oe_n;
		logic [7:0] g_out;
		logic [7:0] g_oe_n;
		logic [7:0] g_pullup;
		logic [7:0] pin_level;
	} gpp_state_t;

	gpp_state_t st;
	gpp_state_t next_st;

	logic       hiz;
	logic [7:0] f_pin;
	logic [7:0] g_pin;
	logic [7:0] f_rd;
	logic [7:0] g_rd;
	logic [7:0] f_drv;
	logic [7:0] g_drv;
	logic [7:0] f_val;
	logic [7:0] g_val;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_st = st;
		hiz = standby_req & st.stby[GPP_SPL_BIT];
		// three-stage capture; a change counts once stages two and
		// three agree, otherwise the previous level is held
		next_st.s1 = pin_in;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < 11; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.pin[i] = st.s3[i];
			end
		end
		// blocked inputs read low while isolated
		f_pin = hiz ? GPP_ZERO8 : {5'h00, st.pin[10:8]};
		g_pin = hiz ? GPP_ZERO8 : st.pin[7:0];
		// read selection per bit: latch for outputs and modify-write
		f_rd = bus.rmw ? st.f_data
			: ((st.f_dir & st.f_data) | (~st.f_dir & f_pin));
		g_rd = bus.rmw ? st.g_data
			: ((st.g_dir & st.g_data) | (~st.g_dir & g_pin));
		// peripheral-driven pins read the pin, carrying its output
		f_rd = bus.rmw ? f_rd
			: ((f_rd & ~{5'h00, periph.f_en})
			| (f_pin & {5'h00, periph.f_en}));
		g_rd = bus.rmw ? g_rd
			: ((g_rd & ~periph.g_en) | (g_pin & periph.g_en));
		next_st.rdata = GPP_ZERO8;
		if (bus.rd) begin
			case (bus.addr)
				GPP_A_F_DATA: next_st.rdata = f_rd & GPP_F_MASK;
				GPP_A_F_DIR:  next_st.rdata = st.f_dir;
				GPP_A_G_DATA: next_st.rdata = g_rd & GPP_G_MASK;
				GPP_A_G_DIR:  next_st.rdata = st.g_dir;
				GPP_A_G_PULL: next_st.rdata = st.g_pull;
				GPP_A_STBY:   next_st.rdata = st.stby;
				default:      next_st.rdata = GPP_ZERO8;
			endcase
		end
		// writes to latches happen regardless of direction
		if (bus.wr) begin
			case (bus.addr)
				GPP_A_F_DATA: next_st.f_data = bus.wdata & GPP_F_MASK;
				GPP_A_F_DIR:  next_st.f_dir = bus.wdata & GPP_F_MASK;
				GPP_A_G_DATA: next_st.g_data = bus.wdata & GPP_G_MASK;
				GPP_A_G_DIR:  next_st.g_dir = bus.wdata & GPP_G_MASK;
				GPP_A_G_PULL: next_st.g_pull = bus.wdata & GPP_G_MASK;
				GPP_A_STBY:   next_st.stby = {7'h00, bus.wdata[GPP_SPL_BIT]};
				default:      next_st.stby = st.stby;
			endcase
		end
		// drive source: peripheral output wins over the latch
		f_val = ({5'h00, periph.f_en} & {5'h00, periph.f_val})
			| (~{5'h00, periph.f_en} & st.f_data);
		g_val = (periph.g_en & periph.g_val)
			| (~periph.g_en & st.g_data);
		f_drv = (st.f_dir | {5'h00, periph.f_en}) & GPP_F_MASK;
		g_drv = (st.g_dir | periph.g_en) & GPP_G_MASK;
		// open-drain pin only pulls low; a one releases it
		f_drv = f_drv & ~({5'h00, GPP_F_OD} & f_val);
		if (hiz) begin
			f_drv = GPP_ZERO8;
			g_drv = GPP_ZERO8;
		end
		next_st.f_out = f_val[2:0];
		next_st.f_oe_n = ~f_drv[2:0];
		next_st.g_out = g_val;
		next_st.g_oe_n = ~g_drv;
		// pull-up drops while the pin is driven low
		next_st.g_pullup = st.g_pull & GPP_G_MASK
			& ~(g_drv & ~g_val);
		// bits without a pad would only echo the board; report zero
		next_st.pin_level = g_pin & GPP_G_MASK;
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
			st.f_dir <= GPP_DIR_RST;
			st.g_dir <= GPP_DIR_RST;
			st.f_data <= GPP_DATA_RST;
			st.g_data <= GPP_DATA_RST;
			st.g_pull <= GPP_PULL_RST;
			st.f_oe_n <= 3'h7;
			st.g_oe_n <= 8'hff;
		end else begin
			st <= next_st;
		end
	end

	assign rdata = st.rdata;
	assign f_out = st.f_out;
	assign f_oe_n = st.f_oe_n;
	assign g_out = st.g_out;
	assign g_oe_n = st.g_oe_n;
	assign g_pullup = st.g_pullup;
	assign pin_level = st.pin_level;

endmodule

/* File: dv/gpp_port_assertions.sv */
// Purpose: port checks for gpp_port
// Assumes: one clock, async low reset
// Notes:   spl shadows the standby pin-state bit
`timescale 1ns/100ps
module gpp_port_chk
	import gpp_pkg::*;
(
	input wire logic        clk,
	input wire logic        arst_n,
	input wire gpp_bus_t    bus,
	input wire logic [7:0]  rdata,
	input wire gpp_pins_t   pin_in,
	input wire logic [2:0]  f_out,
	input wire logic [2:0]  f_oe_n,
	input wire logic [7:0]  g_out,
	input wire logic [7:0]  g_oe_n,
	input wire logic [7:0]  g_pullup,
	input wire gpp_periph_t periph,
	input wire logic        standby_req,
	input wire logic [7:0]  pin_level
);
	// ****************
	// checks
	// ****************
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic standby_pin_state_bit;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			standby_pin_state_bit <= 1'b0;
		else if (bus.wr && bus.addr == GPP_A_STBY)
			standby_pin_state_bit <= bus.wdata[GPP_SPL_BIT];
	end
	sequence s_quiet;
		!standby_pin_state_bit && standby_req && !bus.wr && $stable(periph);
	endsequence
	chk_reset_inputs: assert property (
		$rose(arst_n) |-> &f_oe_n && &g_oe_n) else $error("pin driven");
	chk_od_release: assert property (
		!f_oe_n[2] |-> !f_out[2]) else $error("drain drives high");
	chk_g_unused: assert property (
		&(g_oe_n | GPP_G_MASK)) else $error("unused pin driven");
	chk_pullup_low: assert property (
		(g_pullup & ~g_oe_n & ~g_out) == 8'h00) else $error("pull-up on low");
	chk_rdata_idle: assert property (
		!$past(bus.rd) |-> rdata == 8'h00) else $error("stray read data");
	chk_periph_drive: assert property (
		(periph.g_en[1] && !standby_req && $stable(periph))[*3] |->
		!g_oe_n[1] && g_out[1] == periph.g_val[1]) else $error("no override");
	chk_isolate_pins: assert property (
		(standby_pin_state_bit && standby_req)[*4] |-> &f_oe_n && &g_oe_n &&
		pin_level == 8'h00) else $error("not isolated");
	chk_standby_hold: assert property (
		s_quiet[*3] |=> $stable(f_oe_n) && $stable(g_oe_n))
		else $error("pins moved in standby");
endmodule

/* File: dv/gpp_board.sv */
// Purpose: board side of the pins
// Assumes: released lines take pull-up or bench level
// Notes:   no drive fights modelled
`timescale 1ns/100ps
module gpp_board
	import gpp_pkg::*;
(
	input  wire logic [2:0] f_out,
	input  wire logic [2:0] f_oe_n,
	input  wire logic [7:0] g_out,
	input  wire logic [7:0] g_oe_n,
	input  wire logic [7:0] g_pullup,
	input  wire logic [2:0] f_ext,
	input  wire logic [7:0] g_ext,
	output gpp_pins_t       pin_in
);
	// ****************
	// wire levels
	// ****************
	always_comb begin
		pin_in.f_in = (f_out & ~f_oe_n) | (f_ext & f_oe_n);
		pin_in.g_in = (g_out & ~g_oe_n) | ((g_pullup | g_ext) & g_oe_n);
	end
endmodule

/* File: dv/gpp_port_tb.sv */
// Purpose: directed checks of gpp_port
// Assumes: board model closes the pin loop
// Notes:   pin reads wait out the synchroniser
`timescale 1ns/100ps
module gpp_port_tb;
	import gpp_pkg::*;
	// ****************
	// bench
	// ****************
	logic        clk = 1'b0, arst_n = 1'b0, standby_req = 1'b0;
	gpp_bus_t    bus = '0;
	gpp_periph_t periph = '0;
	gpp_pins_t   pin_in;
	logic [7:0]  rdata, g_out, g_oe_n, g_pullup, pin_level, g_ext = 8'hff;
	logic [2:0]  f_out, f_oe_n, f_ext = 3'h0;
	int          fail_count = 0, comparisons = 0;
	gpp_port DUT (.clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata),
		.pin_in(pin_in), .f_out(f_out), .f_oe_n(f_oe_n), .g_out(g_out),
		.g_oe_n(g_oe_n), .g_pullup(g_pullup), .periph(periph),
		.standby_req(standby_req), .pin_level(pin_level));
	gpp_board board (.f_out(f_out), .f_oe_n(f_oe_n), .g_out(g_out),
		.g_oe_n(g_oe_n), .g_pullup(g_pullup), .f_ext(f_ext),
		.g_ext(g_ext), .pin_in(pin_in));
	initial forever #10 clk = ~clk;
	task automatic chk(string n, logic [7:0] got, logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic wr(logic [2:0] a, logic [7:0] d);
		@(posedge clk) bus <= {a, d, 3'b100};
		@(posedge clk) bus <= '0;
	endtask
	task automatic rd(logic [2:0] a, logic r, logic [7:0] exp);
		@(posedge clk) bus <= {a, 8'h00, 1'b0, 1'b1, r};
		@(posedge clk) bus <= '0;
		#1 chk("rdata", rdata, exp);
	endtask
	task automatic settle;
		repeat (5) @(posedge clk);
		#1;
	endtask
	task automatic t_first;
		rd(GPP_A_F_DIR, 1'b0, GPP_DIR_RST);
		rd(3'h7, 1'b0, 8'h00);
		wr(GPP_A_F_DIR, 8'hff);
		wr(GPP_A_F_DATA, 8'h05);
		settle();
		chk("f_oe_n", {5'h0, f_oe_n}, 8'h04);
		chk("f_out", {6'h0, f_out[1:0]}, 8'h01);
		rd(GPP_A_F_DIR, 1'b0, GPP_F_MASK);
		rd(GPP_A_F_DATA, 1'b0, 8'h05);
		wr(GPP_A_F_DIR, 8'h00);
		wr(GPP_A_F_DATA, 8'h07);
		f_ext <= 3'h2;
		settle();
		chk("f_oe_n", {5'h0, f_oe_n}, 8'h07);
		rd(GPP_A_F_DATA, 1'b0, 8'h02);
		rd(GPP_A_F_DATA, 1'b1, 8'h07);
		@(posedge clk);
		periph.f_en[0] <= 1'b1;
		f_ext <= 3'h3;
		settle();
		chk("f_oe_n", {5'h0, f_oe_n}, 8'h06);
		chk("f_out", {5'h0, f_out}, 8'h06);
		rd(GPP_A_F_DATA, 1'b0, 8'h02);
		rd(GPP_A_F_DATA, 1'b1, 8'h07);
		@(posedge clk);
		periph.f_en[0] <= 1'b0;
	endtask
	task automatic t_second;
		wr(GPP_A_G_DIR, 8'hff);
		wr(GPP_A_G_PULL, 8'hff);
		rd(GPP_A_G_PULL, 1'b0, GPP_G_MASK);
		wr(GPP_A_G_DATA, 8'h02);
		settle();
		chk("g_oe_n", g_oe_n, 8'hf9);
		chk("g_pullup", g_pullup, 8'h02);
		chk("g_out", g_out, 8'h02);
		wr(GPP_A_G_DIR, 8'h00);
		wr(GPP_A_G_DATA, 8'h06);
		periph.g_en[1] <= 1'b1;
		settle();
		chk("g_oe_n", g_oe_n, 8'hfd);
		rd(GPP_A_G_DATA, 1'b0, 8'h04);
		rd(GPP_A_G_DATA, 1'b1, 8'h06);
		chk("pin_level", pin_level, 8'h04);
		chk("g_pullup", g_pullup, 8'h04);
		@(posedge clk);
		periph.g_en[1] <= 1'b0;
	endtask
	task automatic t_standby;
		wr(GPP_A_G_DIR, 8'h06);
		standby_req <= 1'b1;
		settle();
		chk("g_oe_n", g_oe_n, 8'hf9);
		wr(GPP_A_STBY, 8'h01);
		settle();
		chk("g_oe_n", g_oe_n, 8'hff);
		chk("pin_level", pin_level, 8'h00);
		rd(GPP_A_F_DATA, 1'b0, 8'h00);
		@(posedge clk);
		standby_req <= 1'b0;
	endtask
	task automatic t_reset;
		wr(GPP_A_F_DIR, 8'hff);
		wr(GPP_A_G_DIR, 8'hff);
		arst_n <= 1'b0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		#1 chk("f_oe_n", {5'h0, f_oe_n}, 8'h07);
		chk("g_oe_n", g_oe_n, 8'hff);
		rd(GPP_A_F_DIR, 1'b0, GPP_DIR_RST);
		rd(GPP_A_G_DIR, 1'b0, GPP_DIR_RST);
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		t_first();
		t_second();
		t_standby();
		t_reset();
		conclude();
	end
	initial begin
		#100us;
		fail_count++;
		conclude();
	end
endmodule
bind gpp_port gpp_port_chk u_chk (.clk(clk), .arst_n(arst_n), .bus(bus),
	.rdata(rdata), .pin_in(pin_in), .f_out(f_out), .f_oe_n(f_oe_n),
	.g_out(g_out), .g_oe_n(g_oe_n), .g_pullup(g_pullup),
	.periph(periph), .standby_req(standby_req), .pin_level(pin_level));
